// *** csirx_params.svh ***
// offsets, field positions, reset values and timing counts of the csi-2 receiver config bank
// assumes: included by the design file by its bare name
`ifndef CSIRX_PARAMS_SVH
`define CSIRX_PARAMS_SVH

// register indices; byte address is four times the index
`define CSIRX_IDX_LP_POL 10'h021
`define CSIRX_IDX_HS_DBG 10'h022
`define CSIRX_IDX_LP_DBG 10'h023
`define CSIRX_IDX_TERM_DBG 10'h024
`define CSIRX_IDX_HDR_CTRL 10'h031
`define CSIRX_IDX_CTL_CFG 10'h032
`define CSIRX_IDX_HDR_SHOW 10'h040
`define CSIRX_IDX_STATUS 10'h041

// field positions
`define CSIRX_LP_CLK_BIT 4
`define CSIRX_HDR_SEL_HI 7
`define CSIRX_HDR_SEL_LO 6
`define CSIRX_HDR_FIXED_BIT 5
`define CSIRX_HDR_PERVC_BIT 4
`define CSIRX_TINIT_HI 2
`define CSIRX_TINIT_LO 0
`define CSIRX_CTL_ALL_BIT 7
`define CSIRX_CTL_DEC_BIT 6
`define CSIRX_CTL_ACK_BIT 5
`define CSIRX_CTL_PAR_BIT 3

// reset values and the debug write mask
`define CSIRX_RST_LP_POL 8'h00
`define CSIRX_RST_DBG 8'h00
`define CSIRX_RST_HDR_CTRL 8'h20
`define CSIRX_RST_CTL_CFG 8'h09
`define CSIRX_DBG_RW_MASK 8'h7F

// timing
`define CSIRX_CLK_MHZ 200
`define CSIRX_TINIT_STEP_US 100
`define CSIRX_TINIT_STEP_CYC (`CSIRX_TINIT_STEP_US * `CSIRX_CLK_MHZ)

// axi answers
`define CSIRX_RESP_OKAY 2'h0
`define CSIRX_RESP_SLVERR 2'h2

`endif

// *** csirx_pkg.sv ***
// types shared by the csi-2 receiver config bank
// assumes: nothing beyond the params header
`default_nettype none
package csirx_pkg;

	// one lp lane pair: bit 1 positive line, bit 0 negative line
	typedef struct packed {
		logic [1:0] clkLane;
		logic [3:0][1:0] dataLane;
	} csirx_lp_t;

	typedef struct packed {
		logic valid;
		logic [1:0] vc;
		logic [31:0] raw;
		logic [31:0] fixed;
	} csirx_hdr_t;

	typedef struct packed {
		logic valid;
		logic isWrite;
		logic addrMatch;
		logic fwdLock;
		logic remoteAck;
	} csirx_i2c_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic parity;
	} csirx_bc_byte_t;

endpackage

`default_nettype wire

// *** csirx_cfg_regs.sv ***
// csi-2 receiver and control channel configuration bank with axi4-lite access
// assumes: lp lane pins are asynchronous; header, i2c and back channel inputs share ref_clk
//
// Overview of operation
// - one writable bit sets the low-power polarity of the clock lane.
// - a four-bit writable field sets the low-power polarity of each data lane.
// - a two-bit field picks which channel's header is shown, only while per-channel capture is on.
// - per-channel capture keeps one header per virtual channel; plain capture keeps the last one.
// - a select reset to one shows the corrected header, otherwise the header as received.
// - after power-up lp control data are ignored for 100 us times code plus one.
// - the pass-through-all bit forwards every local i2c transaction.
// - the decoded pass-through bit forwards a transaction only on an address match.
// - the auto acknowledge bit acks every i2c write whatever the lock or remote ack.
// - back channel parity is checked while the enable bit, reset to one, is set.
`timescale 1ns/1ps
`default_nettype none
`include "csirx_params.svh"

module csirx_cfg_regs #(
	parameter int STEP_CYCLES = `CSIRX_TINIT_STEP_CYC
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// axi4-lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [11:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [11:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// lp lane pins and their corrected view
	input wire csirx_pkg::csirx_lp_t lpPins,
	output csirx_pkg::csirx_lp_t lpLanes,
	output logic lpWindowDone,
	// receiver debug enables
	output logic [6:0] hsRxDebug,
	output logic [6:0] lpRxDebug,
	output logic [7:0] laneTermDebug,
	// packet headers
	input wire csirx_pkg::csirx_hdr_t hdrIn,
	output logic [31:0] shownHeader,
	// i2c forwarding decision
	input wire csirx_pkg::csirx_i2c_req_t i2cReq,
	output logic i2cDone,
	output logic i2cForward,
	output logic i2cAck,
	// back channel parity
	input wire csirx_pkg::csirx_bc_byte_t bcByte,
	output logic bcParityErr
);

	// register storage
	logic [7:0] lpPol_q, hsDbg_q, lpDbg_q, termDbg_q, hdrCtrl_q, ctlCfg_q;

	// axi state
	logic awready_q, wready_q, bvalid_q, awHave_q, wHave_q, wrLow_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [9:0] wrIdx_q;
	logic [31:0] wrData_q, rdata_q;

	// lp path
	csirx_pkg::csirx_lp_t lpMeta_q, lpSync_q, lpOut_q, lpFixed;
	logic [17:0] winCnt_q, winLimit;
	logic windowDone_q;

	// headers
	logic [31:0] hdrStore_q [4];
	logic [31:0] lastHdr_q, shown_q, hdrPick, shownNext;

	// control channel
	logic i2cDone_q, i2cFwd_q, i2cAck_q, fwdDecision, ackDecision, parErr_q, parMismatch;
	logic [7:0] parCnt_q;

	// write decode
	logic wrEn, wrByte, wrMapped;
	logic [7:0] wrVal;
	logic wrLpPol, wrHsDbg, wrLpDbg, wrTermDbg, wrHdrCtrl, wrCtl;

	// read decode
	logic [9:0] rdIdx;
	logic rdMapped;
	logic [31:0] rdMux;

	assign wrEn = awHave_q && wHave_q && !bvalid_q;
	assign wrByte = wrEn && wrLow_q;
	assign wrVal = wrData_q[7:0];
	assign wrLpPol = wrByte && (wrIdx_q == `CSIRX_IDX_LP_POL);
	assign wrHsDbg = wrByte && (wrIdx_q == `CSIRX_IDX_HS_DBG);
	assign wrLpDbg = wrByte && (wrIdx_q == `CSIRX_IDX_LP_DBG);
	assign wrTermDbg = wrByte && (wrIdx_q == `CSIRX_IDX_TERM_DBG);
	assign wrHdrCtrl = wrByte && (wrIdx_q == `CSIRX_IDX_HDR_CTRL);
	assign wrCtl = wrByte && (wrIdx_q == `CSIRX_IDX_CTL_CFG);
	// status words are mapped but ignore writes
	assign wrMapped = (wrIdx_q == `CSIRX_IDX_LP_POL) || (wrIdx_q == `CSIRX_IDX_HS_DBG)
		|| (wrIdx_q == `CSIRX_IDX_LP_DBG) || (wrIdx_q == `CSIRX_IDX_TERM_DBG)
		|| (wrIdx_q == `CSIRX_IDX_HDR_CTRL) || (wrIdx_q == `CSIRX_IDX_CTL_CFG)
		|| (wrIdx_q == `CSIRX_IDX_HDR_SHOW) || (wrIdx_q == `CSIRX_IDX_STATUS);

	assign rdIdx = araddr[11:2];
	assign rdMapped = (rdIdx == `CSIRX_IDX_LP_POL) || (rdIdx == `CSIRX_IDX_HS_DBG)
		|| (rdIdx == `CSIRX_IDX_LP_DBG) || (rdIdx == `CSIRX_IDX_TERM_DBG)
		|| (rdIdx == `CSIRX_IDX_HDR_CTRL) || (rdIdx == `CSIRX_IDX_CTL_CFG)
		|| (rdIdx == `CSIRX_IDX_HDR_SHOW) || (rdIdx == `CSIRX_IDX_STATUS);
	assign rdMux =
		(rdIdx == `CSIRX_IDX_LP_POL) ? {24'h000000, lpPol_q} :
		(rdIdx == `CSIRX_IDX_HS_DBG) ? {24'h000000, hsDbg_q} :
		(rdIdx == `CSIRX_IDX_LP_DBG) ? {24'h000000, lpDbg_q} :
		(rdIdx == `CSIRX_IDX_TERM_DBG) ? {24'h000000, termDbg_q} :
		(rdIdx == `CSIRX_IDX_HDR_CTRL) ? {24'h000000, hdrCtrl_q} :
		(rdIdx == `CSIRX_IDX_CTL_CFG) ? {24'h000000, ctlCfg_q} :
		(rdIdx == `CSIRX_IDX_HDR_SHOW) ? shown_q :
		(rdIdx == `CSIRX_IDX_STATUS) ? {16'h0000, parCnt_q, 7'h00, windowDone_q} :
		32'h00000000;

	// write address and data are taken in either order, answered once both are held
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `CSIRX_RESP_OKAY;
			wrIdx_q <= 10'h000;
			wrData_q <= 32'h00000000;
			wrLow_q <= 1'b0;
		end
		else
		begin
			if (awvalid && awready_q)
			begin
				awHave_q <= 1'b1;
				awready_q <= 1'b0;
				wrIdx_q <= awaddr[11:2];
			end
			if (wvalid && wready_q)
			begin
				wHave_q <= 1'b1;
				wready_q <= 1'b0;
				wrData_q <= wdata;
				wrLow_q <= wstrb[0];
			end
			if (wrEn)
			begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wrMapped ? `CSIRX_RESP_OKAY : `CSIRX_RESP_SLVERR;
			end
			if (bvalid_q && bready)
			begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `CSIRX_RESP_OKAY;
		end
		else if (arvalid && arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rdMux;
			rresp_q <= rdMapped ? `CSIRX_RESP_OKAY : `CSIRX_RESP_SLVERR;
		end
		else if (rvalid_q && rready)
		begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// configuration registers; only byte lane 0 carries them
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			lpPol_q <= `CSIRX_RST_LP_POL;
			hsDbg_q <= `CSIRX_RST_DBG;
			lpDbg_q <= `CSIRX_RST_DBG;
			termDbg_q <= `CSIRX_RST_DBG;
			hdrCtrl_q <= `CSIRX_RST_HDR_CTRL;
			ctlCfg_q <= `CSIRX_RST_CTL_CFG;
		end
		else
		begin
			if (wrLpPol)
				lpPol_q <= wrVal;
			// bit 7 of the hs and lp debug enables is read-only zero
			if (wrHsDbg)
				hsDbg_q <= wrVal & `CSIRX_DBG_RW_MASK;
			if (wrLpDbg)
				lpDbg_q <= wrVal & `CSIRX_DBG_RW_MASK;
			if (wrTermDbg)
				termDbg_q <= wrVal;
			if (wrHdrCtrl)
				hdrCtrl_q <= wrVal;
			if (wrCtl)
				ctlCfg_q <= wrVal;
		end
	end

	// lp pins cross in two stages before anything looks at them
	always_ff @(posedge ref_clk)
	begin
		lpMeta_q <= lpPins;
		lpSync_q <= lpMeta_q;
	end

	// swap p and n of a lane whose invert bit is set
	always_comb
	begin
		lpFixed = lpSync_q;
		if (lpPol_q[`CSIRX_LP_CLK_BIT])
			lpFixed.clkLane = {lpSync_q.clkLane[0], lpSync_q.clkLane[1]};
		for (int i = 0; i < 4; i++)
		begin
			if (lpPol_q[i])
				lpFixed.dataLane[i] = {lpSync_q.dataLane[i][0], lpSync_q.dataLane[i][1]};
		end
	end

	// window length follows the field live, so a late write still shortens or stretches it
	assign winLimit = 18'(({15'h0000, hdrCtrl_q[`CSIRX_TINIT_HI:`CSIRX_TINIT_LO]} + 18'h00001)
		* 18'(STEP_CYCLES));

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			winCnt_q <= 18'h00000;
			windowDone_q <= 1'b0;
			lpOut_q <= '1;
		end
		else
		begin
			if (!windowDone_q)
				winCnt_q <= winCnt_q + 18'h00001;
			if (!windowDone_q && (winCnt_q + 18'h00001 >= winLimit))
				windowDone_q <= 1'b1;
			// lanes read as stop state until the window ends
			lpOut_q <= windowDone_q ? lpFixed : '1;
		end
	end

	// header capture: corrected or raw picked at capture time
	assign hdrPick = hdrCtrl_q[`CSIRX_HDR_FIXED_BIT] ? hdrIn.fixed : hdrIn.raw;
	assign shownNext = hdrCtrl_q[`CSIRX_HDR_PERVC_BIT]
		? hdrStore_q[hdrCtrl_q[`CSIRX_HDR_SEL_HI:`CSIRX_HDR_SEL_LO]] : lastHdr_q;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < 4; i++)
				hdrStore_q[i] <= 32'h00000000;
			lastHdr_q <= 32'h00000000;
			shown_q <= 32'h00000000;
		end
		else
		begin
			if (hdrIn.valid && hdrCtrl_q[`CSIRX_HDR_PERVC_BIT])
				hdrStore_q[hdrIn.vc] <= hdrPick;
			if (hdrIn.valid)
				lastHdr_q <= hdrPick;
			shown_q <= shownNext;
		end
	end

	// i2c forwarding and acknowledge
	assign fwdDecision = ctlCfg_q[`CSIRX_CTL_ALL_BIT]
		|| (ctlCfg_q[`CSIRX_CTL_DEC_BIT] && i2cReq.addrMatch);
	assign ackDecision = (ctlCfg_q[`CSIRX_CTL_ACK_BIT] && i2cReq.isWrite)
		|| (fwdDecision && i2cReq.fwdLock && i2cReq.remoteAck);

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			i2cDone_q <= 1'b0;
			i2cFwd_q <= 1'b0;
			i2cAck_q <= 1'b0;
		end
		else
		begin
			i2cDone_q <= i2cReq.valid;
			if (i2cReq.valid)
			begin
				i2cFwd_q <= fwdDecision;
				i2cAck_q <= ackDecision;
			end
		end
	end

	// even parity over the byte and its parity bit
	assign parMismatch = bcByte.valid && ctlCfg_q[`CSIRX_CTL_PAR_BIT]
		&& ((^bcByte.data) != bcByte.parity);

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			parErr_q <= 1'b0;
			parCnt_q <= 8'h00;
		end
		else
		begin
			parErr_q <= parMismatch;
			// saturates rather than wraps so a burst is never hidden
			if (parMismatch && (parCnt_q != 8'hFF))
				parCnt_q <= parCnt_q + 8'h01;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign lpLanes = lpOut_q;
	assign lpWindowDone = windowDone_q;
	assign hsRxDebug = hsDbg_q[6:0];
	assign lpRxDebug = lpDbg_q[6:0];
	assign laneTermDebug = termDbg_q;
	assign shownHeader = shown_q;
	assign i2cDone = i2cDone_q;
	assign i2cForward = i2cFwd_q;
	assign i2cAck = i2cAck_q;
	assign bcParityErr = parErr_q;

endmodule // csirx_cfg_regs

`default_nettype wire

// *** csirx_cfg_regs_sva.sv ***
// port checker for the csi-2 receiver config bank
// assumes: bound into csirx_cfg_regs, one clock domain
`timescale 1ns/1ps
`default_nettype none
module csirx_cfg_regs_sva #(
	parameter int STEP_CYCLES = 4
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// lanes
	input wire csirx_pkg::csirx_lp_t lpLanes,
	input wire logic lpWindowDone,
	// i2c and parity
	input wire csirx_pkg::csirx_i2c_req_t i2cReq,
	input wire logic i2cDone,
	input wire logic i2cForward,
	input wire logic i2cAck,
	input wire csirx_pkg::csirx_bc_byte_t bcByte,
	input wire logic bcParityErr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// edges since release; no saturation needed for short runs
	int cycCnt_q;
	always_ff @(posedge ref_clk)
		cycCnt_q <= reset ? 0 : cycCnt_q + 1;
	win_min_a: assert property ($rose(lpWindowDone) |-> cycCnt_q >= STEP_CYCLES)
		else $error("window too short");
	win_max_a: assert property (cycCnt_q > 8 * STEP_CYCLES |-> lpWindowDone)
		else $error("window too long");
	lane_stop_a: assert property (!lpWindowDone |-> &lpLanes)
		else $error("lanes not idle");
	i2c_done_a: assert property (i2cReq.valid |=> i2cDone)
		else $error("no i2c answer");
	fwd_hold_a: assert property (!i2cDone |-> $stable(i2cForward) && $stable(i2cAck))
		else $error("i2c result moved");
	ack_read_a: assert property (i2cDone && !i2cForward && !$past(i2cReq.isWrite) |-> !i2cAck)
		else $error("read acked");
	par_good_a: assert property (bcByte.valid && (^bcByte.data == bcByte.parity) |=> !bcParityErr)
		else $error("good byte flagged");
	par_cause_a: assert property (bcParityErr |-> $past(bcByte.valid))
		else $error("parity pulse alone");
endmodule // csirx_cfg_regs_sva
bind csirx_cfg_regs csirx_cfg_regs_sva #(.STEP_CYCLES(STEP_CYCLES)) i_sva (.ref_clk, .reset, .lpLanes,
	.lpWindowDone, .i2cReq, .i2cDone, .i2cForward, .i2cAck, .bcByte, .bcParityErr);
`default_nettype wire

// *** csirx_sensor_model.sv ***
// image sensor lp line driver
// assumes: bench sets the lane states right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module csirx_sensor_model
(
	// wanted state per lane, bit 4 clock lane
	input wire logic [4:0] lpState,
	// lp pins
	output var csirx_pkg::csirx_lp_t lpPins
);
	// never an equal pair, so a swap always shows
	assign lpPins = {lpState[4], ~lpState[4], lpState[3], ~lpState[3], lpState[2], ~lpState[2],
		lpState[1], ~lpState[1], lpState[0], ~lpState[0]};
endmodule // csirx_sensor_model
`default_nettype wire

// *** csirx_cfg_regs_test.sv ***
// self-checking bench for the csi-2 receiver config bank
// assumes: design, package and checker compiled before
`timescale 1ns/1ps
`default_nettype none
module csirx_cfg_regs_test;
	logic ref_clk = 0, reset = 1, awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
	logic awready, wready, bvalid, arready, rvalid, i2cDone, i2cForward, i2cAck, bcParityErr, lpWindowDone, f;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, shownHeader, v, d, q, r, kept, last, slot [4];
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	logic [4:0] lpState = 0;
	logic [6:0] hsRxDebug, lpRxDebug;
	logic [7:0] laneTermDebug, mdl [6];
	logic [7:0] idx [6] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h31, 8'h32};
	logic [7:0] rst [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h09};
	logic [7:0] msk [6] = '{8'hFF, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'hFF};
	csirx_pkg::csirx_lp_t lpPins, lpLanes;
	csirx_pkg::csirx_hdr_t hdrIn = '0, hv;
	csirx_pkg::csirx_i2c_req_t i2cReq = '0;
	csirx_pkg::csirx_bc_byte_t bcByte = '0;
	int seed = 103, errTotal = 0, checks = 0, parSeen = 0;

	always #2.5 ref_clk = ~ref_clk;

	csirx_sensor_model i_sensor (.lpState, .lpPins);
	csirx_cfg_regs #(.STEP_CYCLES(4)) i_dut (.ref_clk, .reset, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.lpPins, .lpLanes, .lpWindowDone, .hsRxDebug, .lpRxDebug, .laneTermDebug, .hdrIn, .shownHeader,
		.i2cReq, .i2cDone, .i2cForward, .i2cAck, .bcByte, .bcParityErr);

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want)
		begin
			errTotal++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic give_verdict;
		if (errTotal == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// write readies are released by the slave, so bready may stay up
	task automatic axiWr(input logic [7:0] i, input logic [31:0] dat);
		awaddr <= {2'h0, i, 2'h0};
		wdata <= dat;
		awvalid <= '1;
		wvalid <= '1;
		do
		begin
			@(posedge ref_clk);
			if (awready)
				awvalid <= '0;
			if (wready)
				wvalid <= '0;
		end
		while (!bvalid);
		r = 32'(bresp);
	endtask

	task automatic axiRd(input logic [7:0] i);
		araddr <= {2'h0, i, 2'h0};
		arvalid <= '1;
		do
			@(posedge ref_clk);
		while (!arready);
		arvalid <= '0;
		do
			@(posedge ref_clk);
		while (!rvalid);
		d = rdata;
		r = 32'(rresp);
	endtask

	initial
	begin
		repeat (2) @(posedge ref_clk);
		reset <= '0;
		@(posedge ref_clk);
		check(32'({lpWindowDone, lpLanes}), 32'h3FF);
		for (int k = 0; k < 6; k++)
		begin
			axiRd(idx[k]);
			check(d, 32'(rst[k]));
		end
		check(32'(lpWindowDone), 32'h1);
		axiRd(8'h41);
		check(d, 32'h1);
		for (int k = 0; k < 12; k++)
		begin
			v = $random(seed);
			axiWr(idx[k % 6], v);
			axiRd(idx[k % 6]);
			mdl[k % 6] = v[7:0] & msk[k % 6];
			check(d, 32'(mdl[k % 6]));
		end
		check({hsRxDebug, lpRxDebug, laneTermDebug}, {mdl[1][6:0], mdl[2][6:0], mdl[3]});
		axiWr(8'h22, 32'h0);
		check(32'(hsRxDebug), 32'h0);
		axiWr(8'h04, 32'hFF);
		check(r, 32'h2);
		axiRd(8'h04);
		check(d, 32'h0);
		check(r, 32'h2);
		for (int k = 0; k < 8; k++)
		begin
			v = $random(seed);
			q = $random(seed);
			axiWr(8'h21, v);
			lpState <= q[4:0];
			repeat (4) @(posedge ref_clk);
			for (int i = 0; i < 5; i++)
				kept[2 * i +: 2] = {q[i] ^ v[i], ~(q[i] ^ v[i])};
			check(32'(lpLanes), 32'(kept[9:0]));
		end
		for (int k = 0; k < 6; k++)
		begin
			// alternate per-channel capture so both selections are seen
			v = ($random(seed) & 32'hE8) | (32'(k % 2) << 4);
			axiWr(8'h31, v);
			for (int c = 0; c < 5; c++)
			begin
				hv.valid = '1;
				hv.vc = c < 4 ? c[1:0] : 2'($random(seed));
				hv.raw = $random(seed);
				hv.fixed = $random(seed);
				hdrIn <= hv;
				kept = v[5] ? hv.fixed : hv.raw;
				last = kept;
				if (v[4])
					slot[hv.vc] = kept;
				@(posedge ref_clk);
			end
			hdrIn.valid <= '0;
			repeat (3) @(posedge ref_clk);
			check(shownHeader, v[4] ? slot[v[7:6]] : last);
			axiRd(8'h40);
			check(d, v[4] ? slot[v[7:6]] : last);
		end
		for (int k = 0; k < 32; k++)
		begin
			if (k % 8 == 0)
			begin
				v = $random(seed);
				axiWr(8'h32, v);
			end
			q = $random(seed);
			i2cReq <= {1'h1, q[3:0]};
			bcByte <= {1'h1, q[11:4], q[12]};
			@(posedge ref_clk);
			i2cReq.valid <= '0;
			bcByte.valid <= '0;
			#1;
			f = v[7] | (v[6] & q[2]);
			check(32'({i2cDone, i2cForward, i2cAck}), 32'({1'h1, f, (v[5] & q[3]) | (f & q[1] & q[0])}));
			check(32'(bcParityErr), 32'(v[3] & (^q[11:4] ^ q[12])));
			parSeen += int'(v[3] & (^q[11:4] ^ q[12]));
			@(posedge ref_clk);
		end
		axiRd(8'h41);
		check(d, (32'(parSeen) << 8) | 32'h1);
		give_verdict();
	end

	// whole run is a few hundred cycles
	initial
	begin
		#100us;
		errTotal++;
		give_verdict();
	end
endmodule // csirx_cfg_regs_test
`default_nettype wire
